// ---- rtl/machine_check_trap_pkg.sv ----
package machine_check_trap_pkg;

   // Register byte offsets on the AHB-Lite slave
   localparam logic [7:0] OFS_ICPS = 8'h00;
   localparam logic [7:0] OFS_DCPS = 8'h04;
   localparam logic [7:0] OFS_FVA_LO = 8'h08;
   localparam logic [7:0] OFS_FVA_HI = 8'h0C;
   localparam logic [7:0] OFS_MMS = 8'h10;
   localparam logic [7:0] OFS_BUS_STAT = 8'h14;
   localparam logic [7:0] OFS_BEA_LO = 8'h18;
   localparam logic [7:0] OFS_BEA_HI = 8'h1C;
   localparam logic [7:0] OFS_ISUM = 8'h20;
   localparam logic [7:0] OFS_EXCEPTION_SUMMARY = 8'h24;
   localparam logic [7:0] OFS_EXCEPTION_WRITE_MASK = 8'h28;
   localparam logic [7:0] OFS_CTRL = 8'h2C;

   // icache_parity_status fields
   localparam int ICPS_TAG_BIT = 11;
   localparam int ICPS_DATA_BIT = 12;
   localparam int ICPS_TMR_BIT = 13;
   localparam logic [31:0] ICPS_UNLOCK = 32'h0000_1800;

   // dcache_parity_status fields
   localparam int DCPS_LOCK_BIT = 0;
   localparam int DCPS_SE_BIT = 1;
   localparam int DCPS_DA_BIT = 2;
   localparam int DCPS_DB_BIT = 3;
   localparam int DCPS_TA_BIT = 4;
   localparam int DCPS_TB_BIT = 5;
   localparam logic [31:0] DCPS_UNLOCK = 32'h0000_0003;

   // bus_unit_status fields
   localparam int BUS_DPAR_LSB = 0;
   localparam int BUS_TAG_BIT = 4;
   localparam int BUS_MULTI_BIT = 5;
   localparam int BUS_MEM_BIT = 6;

   // mmu_fault_status fields
   localparam int MMS_STORE_BIT = 0;
   localparam int MMS_INFO_LSB = 1;
   localparam int MMS_INFO_W = 16;

   localparam int ISUM_SYSCHK_BIT = 0;
   localparam int CTRL_TMR_LSB = 0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_FFFF;
   localparam logic [4:0] PRIO_BLOCK = 5'h1F;

   localparam int VA_W = 43;
   localparam int PA_HI = 39;
   localparam int PA_LO = 4;

endpackage : machine_check_trap_pkg

// ---- rtl/error_capture.sv ----
`timescale 1ns/1ps
// Summary of operation
// RQ1: Icache and dcache tag and data arrays are parity checked every access.
// RQ2: Fill and backup-cache data checked per longword; backup tag too.
// RQ3: Icache parity error traps before execution, sets tag or data flag.
// RQ4: Icache contents are never invalidated by hardware on this trap.
// RQ5: Dcache data error traps, sets data flag, lock; second error flag.
// RQ6: Same-cycle dcache errors set several flags, not the second flag.
// RQ7: Dcache data error loads fault address with the quadword address.
// RQ8: Dcache tag error traps, sets tag flag, lock, loads block address.
// RQ9: Dcache error locks fault status with instruction info and store bit.
// RQ10: Fill parity error traps, sets per-longword field, multiple flag.
// RQ11: Fill source flag set for memory, clear for backup cache.
// RQ12: Backup-cache errors capture physical address bits 39 to 4.
// RQ13: Backup tag parity error traps, sets tag flag, multiple flag.
// RQ14: Backup hit uses tag compare only; victim uses stored valid/dirty.
// RQ15: Outgoing backup-cache data to the system is not parity checked.
// RQ16: System pulses fill-error one cycle, then normal fill sequence.
// RQ17: Fill-error input only traps; no status is recorded.
// RQ18: System check input masked at level 31 and firmware state.
// RQ19: Hang timeout traps, pulses partial reset, sets timeout flag.
// RQ20: Writing 0x1800 and 0x03 unlocks the parity status registers.
// RQ21: Reading bus status unlocks bus status and error address.
// RQ22: Clearing exception summary unlocks the exception write mask.
// RQ23: Software flushes icache, runs 32 instructions, flushes again.
// RQ24: Reading fault address unlocks fault address and fault status.
// RQ25: Locked registers keep first error; later only mark multiple.
module error_capture
   import machine_check_trap_pkg::*;
(
   input wire logic mclk,
   input wire logic resetn,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hsel,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic ic_access,
   input wire logic ic_tag_par_bad,
   input wire logic ic_data_par_bad,
   input wire logic [1:0] dc_access,
   input wire logic [1:0] dc_data_par_bad,
   input wire logic [1:0] dc_tag_par_bad,
   input wire logic [VA_W-1:0] dc_quad_va,
   input wire logic [VA_W-1:0] dc_block_va,
   input wire logic dc_store,
   input wire logic [MMS_INFO_W-1:0] dc_instr_info,
   input wire logic fill_valid,
   input wire logic [3:0] fill_lw_par_bad,
   input wire logic fill_from_memory,
   input wire logic [PA_HI:PA_LO] fill_octa_pa,
   input wire logic backup_tag_par_bad,
   input wire logic fill_error,
   input wire logic sys_check_req,
   input wire logic [4:0] priority_level,
   input wire logic privileged_firmware_state,
   input wire logic instr_retired,
   output logic machine_check_trap,
   output logic partial_reset
);

   // Async pins from the system pass a two-stage synchroniser
   logic [1:0] ferr_sync_reg, syschk_sync_reg;
   logic ferr_s, syschk_s;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ferr_sync_reg <= 2'h0;
         syschk_sync_reg <= 2'h0;
      end else begin
         ferr_sync_reg <= {ferr_sync_reg[0], fill_error};
         syschk_sync_reg <= {syschk_sync_reg[0], sys_check_req};
      end
   end
   assign ferr_s = ferr_sync_reg[1];
   assign syschk_s = syschk_sync_reg[1];

   // AHB-Lite address phase capture
   logic wr_pend_reg, rd_pend_reg;
   logic [7:0] addr_reg;
   logic ahb_go;
   assign ahb_go = hsel & hready & htrans[1];

   // Registers
   logic ic_tag_reg, ic_data_reg, ic_tmr_reg;
   logic dc_lock_reg, dc_se_reg;
   logic [1:0] dc_derr_reg, dc_terr_reg;
   logic [VA_W-1:0] fva_reg;
   logic mm_lock_reg, mm_store_reg;
   logic [MMS_INFO_W-1:0] mm_info_reg;
   logic [3:0] bus_dpar_reg;
   logic bus_tag_reg, bus_multi_reg, bus_mem_reg;
   logic [PA_HI:PA_LO] bea_reg;
   logic isum_chk_reg;
   logic [31:0] exception_summary_reg, exception_write_mask_reg;
   logic exc_lock_reg;
   logic [31:0] ctrl_reg;
   logic [31:0] hang_cnt_reg;
   logic machine_check_trap_reg, preset_reg;

   // Decoded bus actions
   logic wr_icps, wr_dcps, wr_exception_summary, wr_exception_write_mask, wr_ctrl;
   logic rd_fva, rd_bus_stat;
   assign wr_icps = wr_pend_reg & (addr_reg == OFS_ICPS);
   assign wr_dcps = wr_pend_reg & (addr_reg == OFS_DCPS);
   assign wr_exception_summary = wr_pend_reg & (addr_reg == OFS_EXCEPTION_SUMMARY);
   assign wr_exception_write_mask = wr_pend_reg & (addr_reg == OFS_EXCEPTION_WRITE_MASK);
   assign wr_ctrl = wr_pend_reg & (addr_reg == OFS_CTRL);
   // RQ24 read unlocks fault
   assign rd_fva = rd_pend_reg & (addr_reg == OFS_FVA_LO);
   // RQ21 read unlocks bus
   assign rd_bus_stat = rd_pend_reg & (addr_reg == OFS_BUS_STAT);

   // RQ1 check every access
   logic ic_err;
   assign ic_err = ic_access & (ic_tag_par_bad | ic_data_par_bad);
   logic [1:0] dc_derr, dc_terr;
   assign dc_derr = dc_access & dc_data_par_bad;
   assign dc_terr = dc_access & dc_tag_par_bad;
   logic dc_err;
   assign dc_err = |{dc_derr, dc_terr};
   // RQ2 per-longword checks
   logic [3:0] fill_bad;
   assign fill_bad = fill_valid ? fill_lw_par_bad : 4'h0;
   logic btag_err, bus_err;
   // RQ14 tag parity only flags
   assign btag_err = fill_valid & backup_tag_par_bad;
   assign bus_err = (|fill_bad) | btag_err;
   logic bus_locked;
   assign bus_locked = (|bus_dpar_reg) | bus_tag_reg;

   // RQ18 mask level and firmware
   logic syschk_take;
   assign syschk_take = syschk_s & (priority_level != PRIO_BLOCK)
                        & ~privileged_firmware_state;

   logic hang_expire;
   assign hang_expire = (hang_cnt_reg >= ctrl_reg) & ~instr_retired;

   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         wr_pend_reg <= 1'b0;
         rd_pend_reg <= 1'b0;
         addr_reg <= 8'h00;
      end else begin
         wr_pend_reg <= ahb_go & hwrite;
         rd_pend_reg <= ahb_go & ~hwrite;
         addr_reg <= ahb_go ? haddr[7:0] : addr_reg;
      end
   end

   // Icache status; RQ4 no invalidate output
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         ic_tag_reg <= 1'b0;
         ic_data_reg <= 1'b0;
         ic_tmr_reg <= 1'b0;
      end else begin
         // RQ20 unlock, set wins
         // RQ3 icache flags
         ic_tag_reg <= (ic_access & ic_tag_par_bad) |
            (ic_tag_reg & ~(wr_icps & hwdata == ICPS_UNLOCK));
         ic_data_reg <= (ic_access & ic_data_par_bad) |
            (ic_data_reg & ~(wr_icps & hwdata == ICPS_UNLOCK));
         // RQ19 timeout flag
         ic_tmr_reg <= hang_expire |
            (ic_tmr_reg & ~(wr_icps & hwdata == ICPS_UNLOCK));
      end
   end

   // Dcache status and fault address/status capture
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         dc_lock_reg <= 1'b0;
         dc_se_reg <= 1'b0;
         dc_derr_reg <= 2'h0;
         dc_terr_reg <= 2'h0;
         fva_reg <= '0;
         mm_lock_reg <= 1'b0;
         mm_store_reg <= 1'b0;
         mm_info_reg <= '0;
      end else begin
         if (dc_err & ~dc_lock_reg) begin
            // RQ5 RQ8 first capture
            // RQ6 same cycle flags
            dc_lock_reg <= 1'b1;
            dc_derr_reg <= dc_derr;
            dc_terr_reg <= dc_terr;
         end else if (dc_err) begin
            // RQ25 later only second
            dc_se_reg <= 1'b1;
         end else if (wr_dcps & hwdata == DCPS_UNLOCK) begin
            // RQ20 dcache unlock
            dc_lock_reg <= 1'b0;
            dc_se_reg <= 1'b0;
            dc_derr_reg <= 2'h0;
            dc_terr_reg <= 2'h0;
         end
         if (dc_err & ~mm_lock_reg) begin
            // RQ7 RQ8 fault address
            fva_reg <= (|dc_derr) ? dc_quad_va : dc_block_va;
            // RQ9 lock fault status
            mm_lock_reg <= 1'b1;
            mm_store_reg <= dc_store;
            mm_info_reg <= dc_instr_info;
         end else if (rd_fva) begin
            mm_lock_reg <= 1'b0;
         end
      end
   end

   // Bus unit status, RQ15 no outgoing check
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         bus_dpar_reg <= 4'h0;
         bus_tag_reg <= 1'b0;
         bus_multi_reg <= 1'b0;
         bus_mem_reg <= 1'b0;
         bea_reg <= '0;
      end else begin
         if (bus_err & ~bus_locked) begin
            // RQ10 RQ13 first capture
            bus_dpar_reg <= fill_bad;
            bus_tag_reg <= btag_err;
            // RQ11 fill source
            bus_mem_reg <= fill_from_memory;
            // RQ12 octaword address
            bea_reg <= fill_octa_pa;
         end else if (bus_err) begin
            // RQ25 later only multiple
            bus_multi_reg <= 1'b1;
         end else if (rd_bus_stat) begin
            bus_dpar_reg <= 4'h0;
            bus_tag_reg <= 1'b0;
            bus_multi_reg <= 1'b0;
         end
      end
   end

   // Summary, exceptions, control, hang timer, trap
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         isum_chk_reg <= 1'b0;
         exception_summary_reg <= 32'h0000_0000;
         exception_write_mask_reg <= 32'h0000_0000;
         exc_lock_reg <= 1'b0;
         ctrl_reg <= CTRL_RESET;
         hang_cnt_reg <= 32'h0000_0000;
         machine_check_trap_reg <= 1'b0;
         preset_reg <= 1'b0;
      end else begin
         // RQ18 summary bit
         isum_chk_reg <= syschk_take |
            (isum_chk_reg & ~(rd_pend_reg & addr_reg == OFS_ISUM));
         if (wr_exception_summary) begin
            // RQ22 clear unlocks mask
            exception_summary_reg <= hwdata;
            exc_lock_reg <= (hwdata != 32'h0000_0000);
         end
         if (wr_exception_write_mask & ~exc_lock_reg) begin
            exception_write_mask_reg <= hwdata;
            exc_lock_reg <= 1'b1;
         end
         if (wr_ctrl) begin
            ctrl_reg <= hwdata;
         end
         hang_cnt_reg <= (instr_retired | hang_expire) ? 32'h0000_0000
                         : hang_cnt_reg + 32'h0000_0001;
         // RQ17 fill error trap only
         // RQ3 RQ5 RQ8 RQ10 RQ13 trap
         machine_check_trap_reg <= ic_err | dc_err | bus_err | ferr_s | hang_expire;
         // RQ19 partial reset
         preset_reg <= hang_expire;
      end
   end

   logic [31:0] rdata;
   always_comb begin
      rdata = 32'h0000_0000;
      case (addr_reg)
         OFS_ICPS: begin
            rdata[ICPS_TAG_BIT] = ic_tag_reg;
            rdata[ICPS_DATA_BIT] = ic_data_reg;
            rdata[ICPS_TMR_BIT] = ic_tmr_reg;
         end
         OFS_DCPS: begin
            rdata[DCPS_LOCK_BIT] = dc_lock_reg;
            rdata[DCPS_SE_BIT] = dc_se_reg;
            rdata[DCPS_DB_BIT:DCPS_DA_BIT] = dc_derr_reg;
            rdata[DCPS_TB_BIT:DCPS_TA_BIT] = dc_terr_reg;
         end
         OFS_FVA_LO: rdata = fva_reg[31:0];
         OFS_FVA_HI: rdata[VA_W-33:0] = fva_reg[VA_W-1:32];
         OFS_MMS: begin
            rdata[MMS_STORE_BIT] = mm_store_reg;
            rdata[MMS_INFO_LSB+MMS_INFO_W-1:MMS_INFO_LSB] = mm_info_reg;
         end
         OFS_BUS_STAT: begin
            rdata[BUS_DPAR_LSB+3:BUS_DPAR_LSB] = bus_dpar_reg;
            rdata[BUS_TAG_BIT] = bus_tag_reg;
            rdata[BUS_MULTI_BIT] = bus_multi_reg;
            rdata[BUS_MEM_BIT] = bus_mem_reg;
         end
         OFS_BEA_LO: rdata = {bea_reg[31:PA_LO], 4'h0};
         OFS_BEA_HI: rdata[PA_HI-32:0] = bea_reg[PA_HI:32];
         OFS_ISUM: rdata[ISUM_SYSCHK_BIT] = isum_chk_reg;
         OFS_EXCEPTION_SUMMARY: rdata = exception_summary_reg;
         OFS_EXCEPTION_WRITE_MASK: rdata = exception_write_mask_reg;
         OFS_CTRL: rdata = ctrl_reg;
         default: rdata = 32'h0000_0000;
      endcase
   end

   // Reads take one wait state: the read data is registered
   logic ready_reg;
   always_ff @(posedge mclk or negedge resetn) begin
      if (!resetn) begin
         hrdata <= 32'h0000_0000;
         ready_reg <= 1'b1;
      end else begin
         hrdata <= (ahb_go & ~hwrite) ? 32'h0000_0000 : rdata;
         ready_reg <= ~(ahb_go & ~hwrite);
      end
   end
   assign hreadyout = ready_reg;
   assign hresp = 1'b0;
   assign machine_check_trap = machine_check_trap_reg;
   assign partial_reset = preset_reg;

endmodule : error_capture

// ---- tb/machine_check_trap_properties.sv ----
`timescale 1ns/1ps
module machine_check_trap_properties (
   input wire logic mclk,
   input wire logic resetn,
   input wire logic ic_access,
   input wire logic ic_tag_par_bad,
   input wire logic ic_data_par_bad,
   input wire logic [1:0] dc_access,
   input wire logic [1:0] dc_data_par_bad,
   input wire logic [1:0] dc_tag_par_bad,
   input wire logic fill_valid,
   input wire logic [3:0] fill_lw_par_bad,
   input wire logic backup_tag_par_bad,
   input wire logic fill_error,
   input wire logic instr_retired,
   input wire logic hresp,
   input wire logic machine_check_trap,
   input wire logic partial_reset
);
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!resetn);
   property p_ic_trap;
      ic_access && (ic_tag_par_bad || ic_data_par_bad) |=> machine_check_trap;
   endproperty
   a_ic_trap: assert property (p_ic_trap)
      else $error("no trap after icache parity error");
   property p_dc_data;
      |(dc_access & dc_data_par_bad) |=> machine_check_trap;
   endproperty
   a_dc_data: assert property (p_dc_data)
      else $error("no trap after dcache data error");
   property p_dc_tag;
      |(dc_access & dc_tag_par_bad) |=> machine_check_trap;
   endproperty
   a_dc_tag: assert property (p_dc_tag)
      else $error("no trap after dcache tag error");
   property p_fill;
      fill_valid && (fill_lw_par_bad != 4'h0) |=> machine_check_trap;
   endproperty
   a_fill: assert property (p_fill)
      else $error("no trap after fill parity error");
   property p_btag;
      fill_valid && backup_tag_par_bad |=> machine_check_trap;
   endproperty
   a_btag: assert property (p_btag)
      else $error("no trap after backup tag error");
   property p_fill_err;
      $rose(fill_error) |-> ##[1:4] machine_check_trap;
   endproperty
   a_fill_err: assert property (p_fill_err)
      else $error("no trap after fill error pulse");
   property p_hang;
      partial_reset |-> ##[0:1] machine_check_trap;
   endproperty
   a_hang: assert property (p_hang)
      else $error("partial reset without trap");
   property p_retire;
      instr_retired |=> !partial_reset;
   endproperty
   a_retire: assert property (p_retire)
      else $error("hang timeout despite progress");
   property p_okay;
      hresp == 1'b0;
   endproperty
   a_okay: assert property (p_okay)
      else $error("bus response not okay");
   c_ic: cover property (ic_access && ic_tag_par_bad);
   c_ferr: cover property ($rose(fill_error));
   c_hang: cover property (partial_reset);
endmodule : machine_check_trap_properties

bind error_capture machine_check_trap_properties u_chk (.mclk(mclk), .resetn(resetn),
   .ic_access(ic_access), .ic_tag_par_bad(ic_tag_par_bad),
   .ic_data_par_bad(ic_data_par_bad), .dc_access(dc_access),
   .dc_data_par_bad(dc_data_par_bad), .dc_tag_par_bad(dc_tag_par_bad),
   .fill_valid(fill_valid), .fill_lw_par_bad(fill_lw_par_bad),
   .backup_tag_par_bad(backup_tag_par_bad), .fill_error(fill_error),
   .instr_retired(instr_retired), .hresp(hresp),
   .machine_check_trap(machine_check_trap), .partial_reset(partial_reset));

// ---- tb/sys_bus_model.sv ----
`timescale 1ns/1ps
module sys_bus_model (
   input wire logic mclk,
   output logic fill_valid = 1'b0,
   output logic [3:0] fill_lw_par_bad = 4'h0,
   output logic fill_from_memory = 1'b0,
   output logic [39:4] fill_octa_pa = 36'h0,
   output logic backup_tag_par_bad = 1'b0,
   output logic fill_error = 1'b0,
   output logic sys_check_req = 1'b0
);
   // One beat per fill; gap models a slow memory
   task automatic fill(input logic [3:0] bad, input logic mem, input logic tb,
                       input logic [39:4] pa, input int gap);
      repeat (gap) @(posedge mclk);
      @(posedge mclk);
      fill_valid <= 1'b1;
      fill_lw_par_bad <= bad;
      fill_from_memory <= mem;
      backup_tag_par_bad <= tb;
      fill_octa_pa <= pa;
      @(posedge mclk);
      fill_valid <= 1'b0;
      fill_lw_par_bad <= 4'h0;
      backup_tag_par_bad <= 1'b0;
      fill_octa_pa <= ~pa;
   endtask : fill
   task automatic abort_fill(input logic [39:4] pa);
      @(posedge mclk);
      fill_error <= 1'b1;
      @(posedge mclk);
      fill_error <= 1'b0;
      fill(4'h0, 1'b1, 1'b0, pa, 2);
   endtask : abort_fill
   task automatic sys_check(input int n);
      @(posedge mclk);
      sys_check_req <= 1'b1;
      repeat (n) @(posedge mclk);
      sys_check_req <= 1'b0;
   endtask : sys_check
endmodule : sys_bus_model

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import machine_check_trap_pkg::*;
   logic mclk, resetn = 1'b0, hwrite = 1'b0, hsel = 1'b0;
   logic hresp, hreadyout, machine_check_trap, partial_reset;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
   logic [1:0] htrans = 2'b00, dc_access = 2'b00;
   logic [1:0] dc_data_par_bad = 2'b00, dc_tag_par_bad = 2'b00;
   logic ic_access = 1'b0, ic_tag_par_bad = 1'b0, ic_data_par_bad = 1'b0;
   logic dc_store = 1'b1, instr_retired = 1'b1;
   logic privileged_firmware_state = 1'b0;
   logic [VA_W-1:0] dc_quad_va = 43'h5AB_1234_5678;
   logic [VA_W-1:0] dc_block_va = 43'h3CD_8765_4320;
   logic [MMS_INFO_W-1:0] dc_instr_info = 16'hBEEF;
   logic fill_valid, fill_from_memory, backup_tag_par_bad, fill_error;
   logic sys_check_req;
   logic [3:0] fill_lw_par_bad;
   logic [PA_HI:PA_LO] fill_octa_pa;
   logic [4:0] priority_level = 5'h00;
   int fail_count = 0, cmp_count = 0, cyc = 0, n;
   error_capture u_dut (.mclk(mclk), .resetn(resetn), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hsel(hsel),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .ic_access(ic_access),
      .ic_tag_par_bad(ic_tag_par_bad), .ic_data_par_bad(ic_data_par_bad),
      .dc_access(dc_access), .dc_data_par_bad(dc_data_par_bad),
      .dc_tag_par_bad(dc_tag_par_bad), .dc_quad_va(dc_quad_va),
      .dc_block_va(dc_block_va), .dc_store(dc_store),
      .dc_instr_info(dc_instr_info), .fill_valid(fill_valid),
      .fill_lw_par_bad(fill_lw_par_bad), .fill_from_memory(fill_from_memory),
      .fill_octa_pa(fill_octa_pa), .backup_tag_par_bad(backup_tag_par_bad),
      .fill_error(fill_error), .sys_check_req(sys_check_req),
      .priority_level(priority_level),
      .privileged_firmware_state(privileged_firmware_state),
      .instr_retired(instr_retired), .machine_check_trap(machine_check_trap),
      .partial_reset(partial_reset));
   sys_bus_model u_sys (.mclk(mclk), .fill_valid(fill_valid),
      .fill_lw_par_bad(fill_lw_par_bad), .fill_from_memory(fill_from_memory),
      .fill_octa_pa(fill_octa_pa), .backup_tag_par_bad(backup_tag_par_bad),
      .fill_error(fill_error), .sys_check_req(sys_check_req));
   task automatic end_sim;
      $display("compares %0d mismatches %0d", cmp_count, fail_count);
      if (fail_count == 0 && cmp_count > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : end_sim
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         fail_count++;
         $display("wrong value at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   // Single word transfer; waits on the slave, never on a fixed count
   task automatic ahb(input logic wr, input logic [7:0] a,
                      input logic [31:0] d);
      @(posedge mclk);
      haddr <= {24'h000000, a};
      hwrite <= wr;
      htrans <= 2'b10;
      hsel <= 1'b1;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      htrans <= 2'b00;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge mclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask : ahb
   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      ahb(1'b0, a, 32'h0);
      check(rd, exp);
   endtask : rc
   task automatic dc_err(input logic [1:0] acc, db, tg);
      @(posedge mclk);
      dc_access <= acc;
      dc_data_par_bad <= db;
      dc_tag_par_bad <= tg;
      @(posedge mclk);
      dc_access <= 2'b00;
      dc_data_par_bad <= 2'b00;
      dc_tag_par_bad <= 2'b00;
   endtask : dc_err
   initial begin
      mclk = 1'b0;
      forever #2 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         end_sim;
      end
   end
   initial begin
      repeat (3) @(posedge mclk);
      resetn <= 1'b1;
      rc(OFS_ICPS, 32'h0);
      rc(OFS_CTRL, CTRL_RESET);
      ahb(1'b1, 8'h40, 32'hFFFF_FFFF);
      rc(8'h40, 32'h0);
      @(posedge mclk);
      ic_access <= 1'b1;
      ic_tag_par_bad <= 1'b1;
      @(posedge mclk);
      ic_access <= 1'b0;
      ic_tag_par_bad <= 1'b0;
      rc(OFS_ICPS, 32'h0000_0800);
      repeat (32) @(posedge mclk);
      ahb(1'b1, OFS_ICPS, 32'h0000_0800);
      rc(OFS_ICPS, 32'h0000_0800);
      ahb(1'b1, OFS_ICPS, ICPS_UNLOCK);
      rc(OFS_ICPS, 32'h0);
      dc_err(2'b11, 2'b11, 2'b00);
      rc(OFS_DCPS, 32'h0000_000D);
      ahb(1'b1, OFS_DCPS, DCPS_UNLOCK);
      dc_err(2'b01, 2'b01, 2'b00);
      dc_err(2'b10, 2'b00, 2'b10);
      rc(OFS_DCPS, 32'h0000_0007);
      rc(OFS_MMS, 32'h0001_7DDF);
      rc(OFS_FVA_LO, 32'h1234_5678);
      rc(OFS_FVA_HI, 32'h0000_05AB);
      ahb(1'b1, OFS_DCPS, DCPS_UNLOCK);
      rc(OFS_DCPS, 32'h0);
      dc_err(2'b10, 2'b00, 2'b10);
      rc(OFS_DCPS, 32'h0000_0021);
      rc(OFS_FVA_LO, 32'h8765_4320);
      rc(OFS_FVA_HI, 32'h0000_03CD);
      u_sys.abort_fill(36'h0);
      u_sys.fill(4'b0101, 1'b1, 1'b0, 36'hA_BCDE_F012, 0);
      u_sys.fill(4'h0, 1'b0, 1'b1, 36'h1_2345_6789, 3);
      rc(OFS_BEA_LO, 32'hCDEF_0120);
      rc(OFS_BEA_HI, 32'h0000_00AB);
      rc(OFS_BUS_STAT, 32'h0000_0065);
      u_sys.fill(4'h0, 1'b0, 1'b1, 36'h1_2345_6789, 0);
      rc(OFS_BUS_STAT, 32'h0000_0010);
      rc(OFS_BEA_HI, 32'h0000_0012);
      priority_level <= PRIO_BLOCK;
      u_sys.sys_check(5);
      rc(OFS_ISUM, 32'h0);
      priority_level <= 5'h00;
      privileged_firmware_state <= 1'b1;
      u_sys.sys_check(5);
      rc(OFS_ISUM, 32'h0);
      privileged_firmware_state <= 1'b0;
      u_sys.sys_check(5);
      rc(OFS_ISUM, 32'h0000_0001);
      rc(OFS_ISUM, 32'h0);
      ahb(1'b1, OFS_EXCEPTION_WRITE_MASK, 32'h0000_0005);
      ahb(1'b1, OFS_EXCEPTION_WRITE_MASK, 32'h0000_0007);
      rc(OFS_EXCEPTION_WRITE_MASK, 32'h0000_0005);
      ahb(1'b1, OFS_EXCEPTION_SUMMARY, 32'h0000_0000);
      ahb(1'b1, OFS_EXCEPTION_WRITE_MASK, 32'h0000_0007);
      rc(OFS_EXCEPTION_WRITE_MASK, 32'h0000_0007);
      // Short hang limit keeps the run brief
      ahb(1'b1, OFS_CTRL, 32'h0000_0014);
      instr_retired <= 1'b0;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (partial_reset !== 1'b1 && n < 100);
      check({31'h0, partial_reset}, 32'h1);
      instr_retired <= 1'b1;
      rc(OFS_ICPS, 32'h0000_2000);
      end_sim;
   end
endmodule : tb_top
